// >>> rtl/scd_map.svh
// register-free constants for the sdram command and clock-enable decoder
// assumes inclusion from the package and the decoder only
`ifndef SCD_MAP_SVH
`define SCD_MAP_SVH
`define SCD_AP_BIT 10
`define SCD_BANK_BITS 3
`define SCD_ADDR_BITS 16
`define SCD_CLK_NS 10
`define SCD_XSRD_CLOCKS 200
`define SCD_CKE_MIN_CLOCKS 3
`define SCD_BL4 3'h2
`define SCD_EMR1_SEL 3'h1
`define SCD_MR0_SEL 3'h0
`define SCD_ODT_A2 2
`define SCD_ODT_A6 6
`endif

// >>> rtl/scd_pkg.sv
// types shared by the command and clock-enable decoder
// assumes scd_map.svh is on the include path
package scd_pkg;
`include "scd_map.svh"
   typedef enum logic [3:0] {
      SCD_CMD_NONE, SCD_CMD_MRS, SCD_CMD_REF, SCD_CMD_SRE, SCD_CMD_SRX,
      SCD_CMD_PRE, SCD_CMD_PREA, SCD_CMD_ACT, SCD_CMD_WR, SCD_CMD_WRA,
      SCD_CMD_RD, SCD_CMD_RDA, SCD_CMD_PDE, SCD_CMD_PDX, SCD_CMD_ILLEGAL
   } scd_cmd_t;
   typedef enum logic [2:0] {
      SCD_ST_IDLE, SCD_ST_ACTIVE, SCD_ST_APD, SCD_ST_PPD, SCD_ST_SREF
   } scd_state_t;
   typedef struct packed {
      logic cs_n;
      logic ras_n;
      logic cas_n;
      logic we_n;
      logic cke;
      logic [`SCD_BANK_BITS-1:0] bank;
      logic [`SCD_ADDR_BITS-1:0] addr;
   } scd_pins_t;
   typedef struct packed {
      scd_cmd_t cmd;
      logic [`SCD_BANK_BITS-1:0] bank;
      logic [`SCD_ADDR_BITS-1:0] addr;
      logic valid;
   } scd_decoded_t;
endpackage

// >>> rtl/scd_decoder.sv
// sdram command decoder with clock-enable power states and write byte mask
// assumes pins synchronous to clk; self-refresh exit is taken on the first edge with cke high
// Notes on behaviour
// - commands come from cs, ras, cas and we on one rising edge, with cke from that edge and the one before
// - column access is read or write by we; a10 high adds auto precharge
// - the three bank bits pick the bank of bank-directed commands
// - on mode register set the bank bits pick which mode register loads
// - bursts of length four always complete; controller never cuts them
// - termination input never steers decoding; termination off in self-refresh
// - self-refresh exit is taken on the first clock edge that sees cke high
// - cke falling with nop enters active or precharge power-down; rising exits
// - self-refresh entered by refresh with cke falling, all banks idle
// - write byte stored when its mask is low, kept when high
`timescale 1ns/1ns
`include "scd_map.svh"
module scd_decoder
   import scd_pkg::*;
#(
   parameter int BANKS = 8,
   parameter int BYTES = 2
) (
   input wire logic clk,
   input wire logic resetn,
   input wire scd_pins_t pins,
   input wire logic odt,
   input wire logic [BYTES*8-1:0] wdata,
   input wire logic [BYTES-1:0] wmask,
   input wire logic wdata_valid,
   output scd_decoded_t decoded,
   output scd_state_t power_state,
   output logic [BANKS-1:0] bank_open,
   output logic [BYTES*8-1:0] write_word,
   output logic [BYTES-1:0] write_byte_en,
   output logic write_strobe,
   output logic odt_active,
   output logic read_allowed,
   output logic [`SCD_ADDR_BITS-1:0] emr1,
   output logic [`SCD_ADDR_BITS-1:0] mr0,
   output logic burst_uninterruptible
);
   // the read gate counter is sized to reach the full exit count
   localparam int XSRD_W = $clog2(`SCD_XSRD_CLOCKS + 1);
   typedef struct packed {
      logic cke_prev;
      scd_state_t st;
      scd_decoded_t dec;
      logic [BANKS-1:0] open;
      logic [BYTES*8-1:0] word;
      logic [BYTES-1:0] ben;
      logic wstb;
      logic odt_on;
      logic [XSRD_W-1:0] xsrd_cnt;
      logic rd_ok;
      logic [`SCD_ADDR_BITS-1:0] mr0;
      logic [`SCD_ADDR_BITS-1:0] emr1;
      logic burst4;
   } scd_reg_t;

   // one register image: every state bit moves together on the clock
   scd_reg_t r;
   scd_reg_t next_r;
   scd_cmd_t cmd;
   logic [2:0] strobes;
   logic nop_like;
   logic sref_wake;

   assign strobes = {pins.ras_n, pins.cas_n, pins.we_n};
   // deselect and nop beside a cke fall enter power-down; refresh beside a cke fall enters self-refresh
   assign nop_like = pins.cs_n || (strobes == 3'h7);
   // pins are synchronous, so the wake lands on the first edge that sees cke high;
   // no command has to be registered for it
   // a cke pulse shorter than one clock is missed: the price of a single clock domain
   assign sref_wake = (r.st == SCD_ST_SREF) && pins.cke;

   always_comb begin
      cmd = SCD_CMD_NONE;
      // cs, ras, cas, we and cke are looked at together; odt never enters here
      // cke_prev starts low, so the first edge after reset decodes as a harmless exit
      if (r.cke_prev && pins.cke) begin
         if (pins.cs_n) begin
            cmd = SCD_CMD_NONE;
         end else begin
            unique case (strobes)
               3'h0: cmd = SCD_CMD_MRS;
               3'h1: cmd = SCD_CMD_REF;
               3'h2: cmd = pins.addr[`SCD_AP_BIT] ? SCD_CMD_PREA : SCD_CMD_PRE;
               3'h3: cmd = SCD_CMD_ACT;
               3'h4: cmd = pins.addr[`SCD_AP_BIT] ? SCD_CMD_WRA : SCD_CMD_WR;
               3'h5: cmd = pins.addr[`SCD_AP_BIT] ? SCD_CMD_RDA : SCD_CMD_RD;
               3'h7: cmd = SCD_CMD_NONE;
               default: cmd = SCD_CMD_ILLEGAL;
            endcase
         end
      end else if (r.cke_prev && !pins.cke) begin
         if (nop_like) begin
            cmd = SCD_CMD_PDE;
         end else if (strobes == 3'h1) begin
            cmd = SCD_CMD_SRE;
         end else begin
            cmd = SCD_CMD_ILLEGAL;
         end
      end else if (!r.cke_prev && pins.cke) begin
         cmd = (r.st == SCD_ST_SREF) ? SCD_CMD_SRX : SCD_CMD_PDX;
      end
   end

   always_comb begin
      next_r = r;
      next_r.cke_prev = pins.cke;
      next_r.wstb = 1'b0;
      next_r.dec.cmd = cmd;
      next_r.dec.bank = pins.bank;
      next_r.dec.addr = pins.addr;
      next_r.dec.valid = (cmd != SCD_CMD_NONE);
      unique case (r.st)
         SCD_ST_IDLE, SCD_ST_ACTIVE: begin
            if (cmd == SCD_CMD_PDE) begin
               // open rows choose which power-down flavour
               next_r.st = (|r.open) ? SCD_ST_APD : SCD_ST_PPD;
            end else if (cmd == SCD_CMD_SRE && r.open == '0) begin
               next_r.st = SCD_ST_SREF;
               next_r.odt_on = 1'b0;
               next_r.rd_ok = 1'b0;
            end
         end
         SCD_ST_APD: begin
            if (cmd == SCD_CMD_PDX) begin
               next_r.st = SCD_ST_ACTIVE;
            end
         end
         SCD_ST_PPD: begin
            if (cmd == SCD_CMD_PDX) begin
               next_r.st = SCD_ST_IDLE;
            end
         end
         SCD_ST_SREF: begin
            // mode registers survive self-refresh; only the read gate restarts
            if (sref_wake || cmd == SCD_CMD_SRX) begin
               next_r.st = SCD_ST_IDLE;
               next_r.xsrd_cnt = '0;
            end
         end
         // a corrupted state code falls back to idle with every row closed
         default: begin
            next_r.st = SCD_ST_IDLE;
            next_r.open = '0;
         end
      endcase
      // read gate counts clocks after self-refresh exit
      if (r.st != SCD_ST_SREF && !r.rd_ok) begin
         if (r.xsrd_cnt == XSRD_W'(`SCD_XSRD_CLOCKS - 1)) begin
            next_r.rd_ok = 1'b1;
         end else begin
            next_r.xsrd_cnt = r.xsrd_cnt + XSRD_W'(1);
         end
      end
      unique case (cmd)
         SCD_CMD_ACT: next_r.open[pins.bank] = 1'b1;
         SCD_CMD_PRE, SCD_CMD_WRA, SCD_CMD_RDA: next_r.open[pins.bank] = 1'b0;
         SCD_CMD_PREA: next_r.open = '0;
         SCD_CMD_MRS: begin
            // bank bits select the target register
            if (pins.bank == `SCD_MR0_SEL) begin
               next_r.mr0 = pins.addr;
               // length four bursts run to the end once this is set
               next_r.burst4 = (pins.addr[2:0] == `SCD_BL4);
            end else if (pins.bank == `SCD_EMR1_SEL) begin
               next_r.emr1 = pins.addr;
            end
         end
         default: begin
         end
      endcase
      if (next_r.st == SCD_ST_ACTIVE && next_r.open == '0) begin
         next_r.st = SCD_ST_IDLE;
      end else if (next_r.st == SCD_ST_IDLE && next_r.open != '0) begin
         next_r.st = SCD_ST_ACTIVE;
      end
      // termination follows its pin only when enabled and never in self-refresh
      next_r.odt_on = odt && (next_r.st != SCD_ST_SREF)
         && (next_r.emr1[`SCD_ODT_A2] || next_r.emr1[`SCD_ODT_A6]);
      // mask sampled with its data; a high mask keeps the stored byte
      if (wdata_valid) begin
         next_r.word = wdata;
         next_r.ben = ~wmask;
         next_r.wstb = 1'b1;
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         r <= '0;
         r.st <= SCD_ST_IDLE;
         r.rd_ok <= 1'b1;
      end else begin
         r <= next_r;
      end
   end

   assign decoded = r.dec;
   assign power_state = r.st;
   assign bank_open = r.open;
   assign write_word = r.word;
   assign write_byte_en = r.ben;
   assign write_strobe = r.wstb;
   assign odt_active = r.odt_on;
   assign read_allowed = r.rd_ok;
   assign mr0 = r.mr0;
   assign emr1 = r.emr1;
   // registered so the flag leaves a flip-flop like every other output
   assign burst_uninterruptible = r.burst4;
endmodule

// >>> sim/scd_decoder_chk.sv
// assertions on the decoder ports: decode, mode load, power states, byte mask
// assumes a bind onto scd_decoder that passes its parameters on
`timescale 1ns/1ns
module scd_decoder_chk
   import scd_pkg::*;
#(parameter int BANKS = 8, parameter int BYTES = 2)
(
   input wire logic clk,
   input wire logic resetn,
   input wire scd_pins_t pins,
   input wire logic [BYTES-1:0] wmask,
   input wire logic wdata_valid,
   input wire scd_decoded_t decoded,
   input wire scd_state_t power_state,
   input wire logic [BANKS-1:0] bank_open,
   input wire logic [BYTES-1:0] write_byte_en,
   input wire logic write_strobe,
   input wire logic odt_active,
   input wire logic read_allowed,
   input wire logic [15:0] mr0,
   input wire logic burst_uninterruptible
);
   wire logic [2:0] rcw = {pins.ras_n, pins.cas_n, pins.we_n};
   default clocking @(posedge clk); endclocking
   default disable iff (!resetn);
   // cke high on both edges with the chip selected
   sequence s_sel; pins.cke && $past(pins.cke) && !pins.cs_n; endsequence
   a_act_opens_bank: assert property (s_sel ##0 rcw == 3'h3
      |=> decoded.cmd == SCD_CMD_ACT && bank_open[$past(pins.bank)]) else $error("no activate");
   a_col_kind: assert property (s_sel ##0 rcw[2:1] == 2'h2 |=> decoded.cmd ==
      ($past(pins.we_n) ? ($past(pins.addr[10]) ? SCD_CMD_RDA : SCD_CMD_RD)
      : ($past(pins.addr[10]) ? SCD_CMD_WRA : SCD_CMD_WR))) else $error("bad column op");
   a_mode_load: assert property (s_sel ##0 rcw == 3'h0 && pins.bank == 3'h0
      |=> mr0 == $past(pins.addr)) else $error("mode register not loaded");
   a_burst_flag: assert property (burst_uninterruptible == (mr0[2:0] == 3'h2))
      else $error("burst flag wrong");
   a_sref_entry: assert property (power_state == SCD_ST_IDLE && $fell(pins.cke)
      && !pins.cs_n && rcw == 3'h1 |=> power_state == SCD_ST_SREF && !read_allowed)
      else $error("no self-refresh");
   a_pd_entry: assert property ($fell(pins.cke) && rcw == 3'h7 && !pins.cs_n
      && power_state inside {SCD_ST_IDLE, SCD_ST_ACTIVE}
      |=> power_state == (|$past(bank_open) ? SCD_ST_APD : SCD_ST_PPD)) else $error("bad pd");
   a_odt_sref: assert property (power_state == SCD_ST_SREF [*2] |-> !odt_active)
      else $error("termination on in self-refresh");
   a_mask_beat: assert property (wdata_valid |=> write_strobe
      && write_byte_en == ~$past(wmask)) else $error("byte enables wrong");
   a_read_hold: assert property ($past(power_state) == SCD_ST_SREF
      |-> !read_allowed [*8]) else $error("read allowed too soon");
   // cke seen high in self-refresh ends it at that very edge
   sequence s_wake; power_state == SCD_ST_SREF && pins.cke; endsequence
   a_sref_exit: assert property (s_wake |=> power_state == SCD_ST_IDLE)
      else $error("self-refresh not left");
endmodule

// >>> sim/scd_ctl.sv
// controller model: one command per call, then nop at the same cke level
// assumes the decoder samples the pins on the rising edge of clk
`timescale 1ns/1ns
module scd_ctl
   import scd_pkg::*;
(
   input wire logic clk,
   output scd_pins_t pins
);
   initial pins = {4'h7, 1'b1, 19'h0};
   // only nop follows, so cke holds and exits never carry a command; cke drops only on request
   task issue(input logic k, input logic [3:0] c, input logic [2:0] b, input logic [15:0] a);
      @(posedge clk);
      pins <= {c, k, b, a};
      @(posedge clk);
      pins <= {4'h7, k, ~b, ~a}; // unused lines toggle, so stale values never help
      #1;
   endtask
   // no command rides on the exit: the first edge that sees cke high ends it
   task wake;
      @(posedge clk);
      pins.cke <= 1'b1;
      @(posedge clk);
      #1;
   endtask
endmodule

// >>> sim/tb_sdram_command_and_cke_decoder.sv
// bench for the command and clock-enable decoder
// assumes scd_ctl drives the pins; checker bound at the foot
`timescale 1ns/1ns
module tb_sdram_command_and_cke_decoder;
   import scd_pkg::*;
   logic clk = 0, resetn = 0, odt = 0, wdata_valid = 0;
   logic [15:0] wdata = 16'h0, write_word, emr1, mr0;
   logic [1:0] wmask = 2'h0, write_byte_en;
   logic [7:0] bank_open;
   logic write_strobe, odt_active, read_allowed, burst_uninterruptible;
   scd_pins_t pins;
   scd_decoded_t decoded;
   scd_state_t power_state;
   scd_cmd_t col[4] = '{SCD_CMD_WR, SCD_CMD_RD, SCD_CMD_WRA, SCD_CMD_RDA};
   int mismatches = 0, num_checks = 0, cyc = 0;
   always #5 clk = ~clk;
   scd_ctl i_ctl(.clk(clk), .pins(pins));
   scd_decoder i_dut(
      .clk(clk),
      .resetn(resetn),
      .pins(pins),
      .odt(odt),
      .wdata(wdata),
      .wmask(wmask),
      .wdata_valid(wdata_valid),
      .decoded(decoded),
      .power_state(power_state),
      .bank_open(bank_open),
      .write_word(write_word),
      .write_byte_en(write_byte_en),
      .write_strobe(write_strobe),
      .odt_active(odt_active),
      .read_allowed(read_allowed),
      .emr1(emr1),
      .mr0(mr0),
      .burst_uninterruptible(burst_uninterruptible)
   );
   task chk(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
      end
   endtask
   task wrap_up;
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   // short power-down keeps refresh safe
   task pd(input scd_state_t s, input scd_state_t back);
      i_ctl.issue(0, 4'h7, 3'h0, 16'h0);
      chk(power_state, s);
      repeat (2) @(posedge clk);
      i_ctl.issue(1, 4'h7, 3'h0, 16'h0);
      chk(power_state, back);
      repeat (2) @(posedge clk);
   endtask
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         mismatches++;
         wrap_up;
      end
   end
   initial begin
      repeat (16) @(posedge clk);
      resetn <= 1;
      repeat (3) @(posedge clk);
      i_ctl.issue(1, 4'h0, 3'h0, 16'h0002);
      chk(mr0, 16'h0002);
      chk(burst_uninterruptible, 1);
      i_ctl.issue(1, 4'h0, 3'h1, 16'h0044);
      chk(emr1, 16'h0044);
      @(posedge clk);
      odt <= 1; // a defined level throughout power-down
      i_ctl.issue(1, 4'h3, 3'h2, 16'h0010);
      chk(decoded.cmd, SCD_CMD_ACT);
      chk(decoded.bank, 3'h2);
      chk(decoded.addr, 16'h0010);
      chk(decoded.valid, 1);
      chk(bank_open, 8'h04);
      chk(odt_active, 1);
      for (int i = 0; i < 4; i++) begin
         i_ctl.issue(1, {3'h2, i[0]}, 3'h2, {5'h0, i[1], 10'h0});
         chk(decoded.cmd, col[i]);
      end
      @(posedge clk);
      wdata <= 16'ha5c3;
      wmask <= 2'h1;
      wdata_valid <= 1;
      @(posedge clk);
      wdata_valid <= 0;
      #1;
      chk(write_byte_en, 2'h2);
      chk(write_word, 16'ha5c3);
      chk(write_strobe, 1);
      i_ctl.issue(1, 4'h3, 3'h5, 16'h0);
      pd(SCD_ST_APD, SCD_ST_ACTIVE);
      i_ctl.issue(1, 4'h3, 3'h1, 16'h0);
      i_ctl.issue(1, 4'h2, 3'h1, 16'h0);
      chk(decoded.cmd, SCD_CMD_PRE);
      chk(bank_open, 8'h20);
      i_ctl.issue(1, 4'h2, 3'h0, 16'h0400);
      chk(bank_open, 8'h00);
      pd(SCD_ST_PPD, SCD_ST_IDLE);
      i_ctl.issue(1, 4'h1, 3'h0, 16'h0);
      chk(decoded.cmd, SCD_CMD_REF);
      i_ctl.issue(0, 4'h1, 3'h0, 16'h0);
      chk(power_state, SCD_ST_SREF);
      repeat (3) @(posedge clk);
      #1;
      chk(odt_active, 0);
      i_ctl.wake;
      chk(power_state, SCD_ST_IDLE);
      repeat (199) @(posedge clk); // nop only through the exit delay
      #1;
      chk(read_allowed, 0);
      @(posedge clk);
      #1;
      chk(read_allowed, 1);
      wrap_up;
   end
endmodule
bind scd_decoder scd_decoder_chk #(.BANKS(BANKS), .BYTES(BYTES)) i_chk(
   .clk(clk),
   .resetn(resetn),
   .pins(pins),
   .wmask(wmask),
   .wdata_valid(wdata_valid),
   .decoded(decoded),
   .power_state(power_state),
   .bank_open(bank_open),
   .write_byte_en(write_byte_en),
   .write_strobe(write_strobe),
   .odt_active(odt_active),
   .read_allowed(read_allowed),
   .mr0(mr0),
   .burst_uninterruptible(burst_uninterruptible)
);
